// ==== dbsp_map.svh ====
// constant map for the ddr burst sram port
`ifndef DBSP_MAP_SVH
`define DBSP_MAP_SVH
`define DBSP_DATA_W 36
`define DBSP_ADDR_W 19
`define DBSP_LANE_W 9
`define DBSP_LANES 4
`define DBSP_BURST 2
`define DBSP_LAT_PLL 3'h5
`define DBSP_LAT_BYP 3'h2
`endif

// ==== dbsp_pkg.sv ====
// types shared by the ddr burst sram port
`default_nettype none
package dbsp_pkg;
  // one sampled link edge view
  typedef struct packed {
    logic kp;
    logic kn;
  } dbsp_clk_s;
  typedef enum logic [1:0] {
    DBSP_IDLE,
    DBSP_RD,
    DBSP_WR
  } dbsp_op_e;
endpackage
`default_nettype wire

// ==== dbsp_sync.sv ====
// two flip-flop synchroniser for a group of pin inputs
`default_nettype none
module dbsp_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;
  // meta feeds only the second stage
  always_comb begin
    next_meta = d_in;
    next_q = meta;
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta <= '0;
      q_out <= '0;
    end else begin
      meta <= next_meta;
      q_out <= next_q;
    end
  end
endmodule
`default_nettype wire

// ==== dbsp_port.sv ====
// ddr burst sram port: pin-level device behaviour over a sampled link clock
// ============================================================
`include "dbsp_map.svh"
`default_nettype none
module dbsp_port
  import dbsp_pkg::*;
#(
  parameter int DATA_W = `DBSP_DATA_W,
  parameter int ADDR_W = `DBSP_ADDR_W
) (
  // system
  input wire logic clk_in,
  input wire logic reset_in,
  // link clocks and control
  input wire logic k_pos_in,
  input wire logic k_neg_in,
  input wire logic cycle_strobe_n_in,
  input wire logic read_not_write_in,
  input wire logic pll_bypass_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W/`DBSP_LANE_W-1:0] byte_lane_select_n_in,
  // shared data pins
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_out,
  // read timing outputs
  output logic echo_timing_out,
  output logic echo_timing_n_out,
  output logic out_valid_out
);
  localparam int LANES = DATA_W / `DBSP_LANE_W;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int SW = 1 + 1 + 1 + 1 + ADDR_W + LANES + DATA_W;

  // only the two documented widths, refused at elaboration
  if (!(DATA_W == 18 || DATA_W == 36) || ADDR_W < 1 || ADDR_W > 20) begin : g_bad_width
    $error("dbsp_port: unsupported width");
  end

  // ============================================================
  // pin synchronisers
  logic [SW-1:0] raw;
  logic [SW-1:0] syn;
  assign raw = {k_pos_in, k_neg_in, cycle_strobe_n_in, read_not_write_in, addr_in,
                byte_lane_select_n_in, dq_in};
  dbsp_sync #(.W(SW)) u_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .d_in(raw),
    .q_out(syn)
  );
  logic [DATA_W-1:0] s_dq;
  logic [LANES-1:0] s_bws;
  logic [ADDR_W-1:0] s_addr;
  logic s_rw;
  logic s_ld;
  dbsp_clk_s s_k;
  assign s_dq = syn[DATA_W-1:0];
  assign s_bws = syn[DATA_W +: LANES];
  assign s_addr = syn[DATA_W+LANES +: ADDR_W];
  assign s_rw = syn[DATA_W+LANES+ADDR_W];
  assign s_ld = syn[DATA_W+LANES+ADDR_W+1];
  assign s_k = syn[SW-1 -: 2];

  // ============================================================
  // edge detection and mode strap
  dbsp_clk_s k_prev;
  logic bypass;
  logic bypass_meta;
  logic rise_p;
  logic rise_n;
  assign rise_p = s_k.kp & ~k_prev.kp;
  assign rise_n = s_k.kn & ~k_prev.kn;

  // ============================================================
  // storage: two arrays, one per burst word
  // word 0 in array 0, word 1 in array 1
  logic [DATA_W-1:0] arr0 [DEPTH];
  logic [DATA_W-1:0] arr1 [DEPTH];

  // ============================================================
  // access state
  dbsp_op_e op, next_op;
  logic [ADDR_W-1:0] addr, next_addr;
  logic beat, next_beat;           // which word of the write burst comes next
  // one slot per link half-cycle, deep enough for the longer latency
  localparam int PIPE = `DBSP_LAT_PLL;
  logic [PIPE-1:0] pipe_v, next_pipe_v;  // read loads in flight
  logic [ADDR_W-1:0] pipe_a [PIPE];      // their addresses
  logic [ADDR_W-1:0] next_pipe_a [PIPE];
  logic [2:0] lat_ix;                    // slot whose load launches word 0 now
  // latency picked by the synchronised strap
  // limitation: flipping the strap with reads in flight is not supported
  assign lat_ix = bypass ? (`DBSP_LAT_BYP - 3'h1) : (`DBSP_LAT_PLL - 3'h1);
  logic [ADDR_W-1:0] rd_addr, next_rd_addr;
  logic [1:0] rd_left, next_rd_left; // read words still to launch
  logic rd_word, next_rd_word;
  logic [DATA_W-1:0] next_dq;
  logic next_oe;
  logic next_vld;
  logic wr0, wr1;                   // write strobes for each array
  logic [DATA_W-1:0] wmask;

  // lane mask from active-low selects
  always_comb begin
    wmask = '0;
    for (int i = 0; i < LANES; i++) begin
      wmask[i*`DBSP_LANE_W +: `DBSP_LANE_W] = {`DBSP_LANE_W{~s_bws[i]}};
    end
  end

  // next-state for command, write and read pipelines
  always_comb begin
    next_op = op;
    next_addr = addr;
    next_beat = beat;
    next_pipe_v = pipe_v;
    next_pipe_a = pipe_a;
    next_rd_addr = rd_addr;
    next_rd_left = rd_left;
    next_rd_word = rd_word;
    next_dq = dq_out;
    next_oe = dq_oe_out;
    next_vld = out_valid_out;
    wr0 = 1'b0;
    wr1 = 1'b0;
    // write words taken on the rises after the load edge
    if (op == DBSP_WR && (rise_p || rise_n)) begin
      if (!beat) begin
        wr0 = 1'b1;
        next_beat = 1'b1;
      end else begin
        wr1 = 1'b1;
        next_beat = 1'b0;
        next_op = DBSP_IDLE;
      end
    end
    // read pipeline shifts on every link rise; a pipeline rather than a
    // single counter so loads on every positive rise never lose a burst
    if (rise_p || rise_n) begin
      next_pipe_v = {pipe_v[PIPE-2:0], 1'b0};
      for (int i = PIPE - 1; i > 0; i--) begin
        next_pipe_a[i] = pipe_a[i-1];
      end
      // launch a read word on each rise that has one due, else release the pins
      if (pipe_v[lat_ix]) begin
        // word 0 leaves on the rise that ends the latency
        next_dq = arr0[pipe_a[lat_ix]];
        next_rd_addr = pipe_a[lat_ix];
        next_rd_word = 1'b1;
        next_rd_left = 2'(`DBSP_BURST - 1);
        next_oe = 1'b1;
        next_vld = 1'b1;
      end else if (rd_left != 2'h0) begin
        next_dq = rd_word ? arr1[rd_addr] : arr0[rd_addr];
        next_rd_word = ~rd_word;
        next_rd_left = rd_left - 2'h1;
        next_oe = 1'b1;
        next_vld = 1'b1;
      end else begin
        next_oe = 1'b0;
        next_vld = 1'b0;
      end
    end
    if (rise_p && !s_ld) begin
      // address used as a flat index
      next_addr = s_addr;
      next_beat = 1'b0;
      if (s_rw) begin
        next_op = DBSP_RD;
        // a new read enters the first pipeline slot
        next_pipe_v[0] = 1'b1;
        next_pipe_a[0] = s_addr;
      end else begin
        next_op = DBSP_WR;
      end
    end
  end

  // state registers
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      k_prev <= '0;
      bypass_meta <= 1'b0;
      bypass <= 1'b0;
      op <= DBSP_IDLE;
      addr <= '0;
      beat <= 1'b0;
      pipe_v <= '0;
      pipe_a <= '{default: '0};
      rd_addr <= '0;
      rd_left <= 2'h0;
      rd_word <= 1'b0;
      dq_out <= '0;
      dq_oe_out <= 1'b0;
      out_valid_out <= 1'b0;
      echo_timing_out <= 1'b0;
      echo_timing_n_out <= 1'b0;
    end else begin
      k_prev <= s_k;
      bypass_meta <= ~pll_bypass_n_in;
      bypass <= bypass_meta;
      op <= next_op;
      addr <= next_addr;
      beat <= next_beat;
      pipe_v <= next_pipe_v;
      pipe_a <= next_pipe_a;
      rd_addr <= next_rd_addr;
      rd_left <= next_rd_left;
      rd_word <= next_rd_word;
      dq_out <= next_dq;
      dq_oe_out <= next_oe;
      out_valid_out <= next_vld;
      // echoes follow the sampled input clocks
      echo_timing_out <= s_k.kp;
      echo_timing_n_out <= s_k.kn;
    end
  end

  // array writes; no reset since contents are undefined at power up
  always_ff @(posedge clk_in) begin
    // deselected lanes keep the stored byte
    if (wr0) begin
      arr0[addr] <= (arr0[addr] & ~wmask) | (s_dq & wmask);
    end
    if (wr1) begin
      arr1[addr] <= (arr1[addr] & ~wmask) | (s_dq & wmask);
    end
  end
endmodule
`default_nettype wire

// ==== dbsp_port_props.sv ====
// assertion checker for the ddr burst sram port
`default_nettype none
module dbsp_port_props #(
  parameter int DATA_W = 36
) (
  // watched ports
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic k_pos_in,
  input wire logic k_neg_in,
  input wire logic cycle_strobe_n_in,
  input wire logic read_not_write_in,
  input wire logic pll_bypass_n_in,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe_out,
  input wire logic echo_timing_out,
  input wire logic echo_timing_n_out,
  input wire logic out_valid_out
);
  // ==========
  // load sequences, raw pins, so ranges allow for the sync delay
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_rd_load;
    $rose(k_pos_in) && !cycle_strobe_n_in && read_not_write_in;
  endsequence
  sequence s_wr_load;
    $rose(k_pos_in) && !cycle_strobe_n_in && !read_not_write_in;
  endsequence
  chk_rd_lat_pll: assert property (
    s_rd_load ##0 pll_bypass_n_in |-> ##[18:28] out_valid_out) else $error("late read");
  chk_rd_lat_byp: assert property (
    s_rd_load ##0 !pll_bypass_n_in |-> ##[6:14] out_valid_out) else $error("late read");
  chk_wr_no_drive: assert property (
    s_wr_load |-> !dq_oe_out [*8]) else $error("driven in write");
  chk_oe_is_valid: assert property (
    dq_oe_out == out_valid_out) else $error("oe and valid differ");
  chk_beat_stable: assert property (
    $rose(out_valid_out) |=> $stable(dq_out) [*2]) else $error("beat not held");
  chk_two_beats: assert property (
    $rose(out_valid_out) |-> out_valid_out [*7]) else $error("burst too short");
  chk_valid_echo: assert property (
    $rose(out_valid_out) |-> $changed(echo_timing_out)) else $error("valid off echo");
  chk_echo_follow: assert property (
    $rose(k_pos_in) |-> ##[1:6] $rose(echo_timing_out)) else $error("echo missing");
  chk_echo_n_follow: assert property (
    $rose(k_neg_in) |-> ##[1:6] $rose(echo_timing_n_out)) else $error("neg echo missing");
endmodule
bind dbsp_port dbsp_port_props #(.DATA_W(DATA_W)) dbsp_port_props_i (
  .clk_in(clk_in), .reset_in(reset_in), .k_pos_in(k_pos_in), .k_neg_in(k_neg_in),
  .cycle_strobe_n_in(cycle_strobe_n_in), .read_not_write_in(read_not_write_in),
  .pll_bypass_n_in(pll_bypass_n_in), .dq_out(dq_out), .dq_oe_out(dq_oe_out),
  .echo_timing_out(echo_timing_out), .echo_timing_n_out(echo_timing_n_out),
  .out_valid_out(out_valid_out));
`default_nettype wire

// ==== dbsp_host_model.sv ====
// host-side model: free link clocks and the shared data wire
`default_nettype none
module dbsp_host_model #(
  parameter int DATA_W = 36
) (
  // both drivers of the wire
  input wire logic [DATA_W-1:0] host_dq_in,
  input wire logic host_oe_in,
  input wire logic [DATA_W-1:0] dev_dq_in,
  input wire logic dev_oe_in,
  // link side
  output logic k_pos_out,
  output logic k_neg_out,
  output logic [DATA_W-1:0] wire_dq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // link clock, odd offset so it never lines up with clk
  initial begin
    k_pos_out = 1'b0;
    #37;
    forever #160 k_pos_out = ~k_pos_out;
  end
  always_comb k_neg_out = ~k_pos_out;
  // released wire shows inverse of last host word, not a stale match
  always_comb begin
    if (dev_oe_in) wire_dq_out = dev_dq_in;
    else if (host_oe_in) wire_dq_out = host_dq_in;
    else wire_dq_out = ~host_dq_in;
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the ddr burst sram port
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, stb_n, rnw, byp_n, host_oe, oe, vld, e, en, kp, kn;
  logic [18:0] addr;
  logic [3:0] lanes;
  logic [35:0] host_dq, dq_w, dq_o;
  logic [35:0] m0[int], m1[int];
  logic [18:0] ad[4];
  int seed, n_fail, tests_run;
  dbsp_host_model dbsp_host_model_i (.host_dq_in(host_dq), .host_oe_in(host_oe),
    .dev_dq_in(dq_o), .dev_oe_in(oe), .k_pos_out(kp), .k_neg_out(kn), .wire_dq_out(dq_w));
  dbsp_port dbsp_port_i (.clk_in(clk), .reset_in(rst), .k_pos_in(kp), .k_neg_in(kn),
    .cycle_strobe_n_in(stb_n), .read_not_write_in(rnw), .pll_bypass_n_in(byp_n),
    .addr_in(addr), .byte_lane_select_n_in(lanes), .dq_in(dq_w), .dq_out(dq_o),
    .dq_oe_out(oe), .echo_timing_out(e), .echo_timing_n_out(en), .out_valid_out(vld));
  // ==========
  // helpers: merge keeps lanes whose select is high
  function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] n, logic [3:0] b);
    for (int i = 0; i < 4; i++) if (!b[i]) o[i*9+:9] = n[i*9+:9];
    return o;
  endfunction
  task chk(input logic [35:0] got, input logic [35:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("BAD %0t got %h want %h", $time, got, exp);
      n_fail++;
    end
  endtask
  // strobe low around one positive rise, dropped two clk falls later
  task load(input logic rd, input logic [18:0] a);
    @(posedge kn);
    @(negedge clk);
    stb_n = 1'b0;
    rnw = rd;
    addr = a;
    @(posedge kp);
    repeat (2) @(negedge clk);
    stb_n = 1'b1;
    rnw = 1'($random(seed));
    addr = 19'($random(seed));
  endtask
  // random full-width data word
  function automatic logic [35:0] rnd36();
    return 36'({$random(seed), $random(seed)});
  endfunction
  // host wiring of address bits in a rotated order
  function automatic logic [18:0] perm(logic [18:0] a);
    return {a[9:0], a[18:10]};
  endfunction
  task wr(input logic [18:0] a, input logic [35:0] w0, w1, input logic [3:0] b0, b1);
    load(1'b0, a);
    host_dq = w0;
    lanes = b0;
    host_oe = 1'b1;
    @(posedge kn);
    repeat (2) @(negedge clk);
    host_dq = w1;
    lanes = b1;
    @(posedge kp);
    repeat (2) @(negedge clk);
    host_oe = 1'b0;
    lanes = 4'($random(seed));
    m0[a] = merge(m0[a], w0, b0);
    m1[a] = merge(m1[a], w1, b1);
  endtask
  // lat counts link rises to the first word
  task rd(input logic [18:0] a, input int lat);
    load(1'b1, a);
    repeat (lat) @(posedge kp or posedge kn);
    repeat (5) @(negedge clk);
    chk(dq_o, m0[a]);
    chk({34'h0, vld, oe}, 36'h3);
    repeat (4) @(negedge clk);
    chk(dq_o, m1[a]);
    repeat (4) @(negedge clk);
    chk({34'h0, vld, oe}, 36'h0);
  endtask
  // two reads on consecutive positive rises: four words, valid unbroken
  task rd2(input logic [18:0] a, input logic [18:0] b);
    load(1'b1, a);
    load(1'b1, b);
    repeat (3) @(posedge kp or posedge kn);
    repeat (5) @(negedge clk);
    chk(dq_o, m0[a]);
    repeat (4) @(negedge clk);
    chk(dq_o, m1[a]);
    repeat (4) @(negedge clk);
    chk(dq_o, m0[b]);
    chk({34'h0, vld, oe}, 36'h3);
    repeat (4) @(negedge clk);
    chk(dq_o, m1[b]);
    repeat (4) @(negedge clk);
    chk({34'h0, vld, oe}, 36'h0);
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #200000;
    n_fail++;
    tally_and_finish;
  end
  // ==========
  // main sequence: full writes, one word-0 lane at a time, back-to-back reads,
  // then bypass latency
  initial begin
    seed = 32'h3b7ae1a3;
    {rst, stb_n, rnw, byp_n, host_oe, addr, lanes, host_dq} = {5'h1a, 59'h0};
    repeat (12) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      ad[i] = 19'($random(seed));
      wr(ad[i], rnd36(), rnd36(), 4'h0, 4'h0);
      rd(ad[i], 5);
    end
    for (int l = 0; l < 4; l++) begin
      wr(ad[l], rnd36(), {17'h0, ~ad[l]}, ~(4'h1 << l), 4'($random(seed)));
      rd(ad[l], 5);
    end
    wr(perm(ad[0]), rnd36(), rnd36(), 4'h0, 4'h0);
    rd2(perm(ad[0]), ad[1]);
    byp_n = 1'b0;
    repeat (10) @(negedge clk);
    for (int i = 0; i < 4; i++) rd(ad[i], 2);
    tally_and_finish;
  end
endmodule
`default_nettype wire
